// >>> hdl/psir_pkg.sv
// Shared constants and types for the PHY status and interrupt register bank.
package psir_pkg;

  // ==========================================================================
  // Register addresses on the management interface
  // ==========================================================================
  localparam logic [4:0] REG_EXT_STATUS   = 5'h0f;
  localparam logic [4:0] REG_LOOP_LED     = 5'h11;
  localparam logic [4:0] REG_CABLE_DIAG   = 5'h12;
  localparam logic [4:0] REG_LINK_STATUS  = 5'h13;
  localparam logic [4:0] REG_RX_ERR_COUNT = 5'h15;
  localparam logic [4:0] REG_INT_CTRL     = 5'h1b;
  localparam logic [4:0] REG_PHY_CTRL     = 5'h1f;

  // ==========================================================================
  // Field values, positions and reset values
  // ==========================================================================
  localparam logic [15:0] EXT_STATUS_VALUE = 16'h3000;
  localparam logic [15:0] LOOP_LED_RESET   = 16'h02f0;
  localparam logic [15:0] LOOP_LED_WMASK   = 16'hfffe;
  localparam int          LOOP_REMOTE_BIT  = 8;
  localparam int          LOOP_LED_BIT     = 3;
  localparam int          LINK_1000_BIT    = 2;
  localparam int          LINK_100_BIT     = 1;
  localparam int          NUM_EVENTS       = 8;
  localparam int          INT_EN_LSB       = 8;
  localparam int          INT_LEVEL_BIT    = 14;
  localparam int          ERR_COUNT_WIDTH  = 16;
  localparam logic        IRQ_PIN_RESET    = 1'b1;

  // Event indices inside the flag and enable bytes.
  localparam int EVT_LINK_UP      = 0;
  localparam int EVT_REMOTE_FAULT = 1;
  localparam int EVT_LINK_DOWN    = 2;
  localparam int EVT_LP_ACK       = 3;
  localparam int EVT_PAR_FAULT    = 4;
  localparam int EVT_PAGE_RX      = 5;
  localparam int EVT_RX_ERROR     = 6;
  localparam int EVT_JABBER       = 7;

  // ==========================================================================
  // Serial management frame
  // ==========================================================================
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [5:0] FIELD_LAST    = 6'h04;
  localparam logic [5:0] DATA_LAST     = 6'h0f;

  typedef enum logic [2:0] {
    PSIR_IDLE  = 3'b000,
    PSIR_START = 3'b001,
    PSIR_OPC   = 3'b010,
    PSIR_PHYA  = 3'b011,
    PSIR_REGA  = 3'b100,
    PSIR_TURN  = 3'b101,
    PSIR_DATA  = 3'b110
  } psir_mdio_state_t;

endpackage : psir_pkg

// >>> hdl/psir_err_count.sv
// Saturating receive symbol error counter that clears when it is read.
`timescale 1ns/1ps
`default_nettype none

module psir_err_count #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             inc_in,
  input  wire logic             clr_in,
  output logic      [WIDTH-1:0] count_out
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } psir_cnt_state_t;

  psir_cnt_state_t st_ff;
  psir_cnt_state_t nxt_st;

  // ==========================================================================
  // Counter
  // ==========================================================================
  // A read clears the count, but an error in the same cycle counts as one.
  always_comb begin
    nxt_st = st_ff;
    if (clr_in) begin
      nxt_st.count = inc_in ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
    end else if (inc_in && (st_ff.count != '1)) begin
      nxt_st.count = st_ff.count + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count_out = st_ff.count;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  count_clear_a: assert property (clr_in |=> count_out == WIDTH'(inc_in))
    else $error("Error count not cleared by read.");
  count_step_a: assert property (
    inc_in && !clr_in && (count_out != '1) |=> count_out == $past(count_out) + 1'b1)
    else $error("Error count did not advance.");

endmodule : psir_err_count
`default_nettype wire

// >>> hdl/psir_evt_flags.sv
// Sticky event flags that are cleared when their register is read.
`timescale 1ns/1ps
`default_nettype none

module psir_evt_flags #(
  parameter int NUM = 8
) (
  input  wire logic           clk_in,
  input  wire logic           rst_n_in,
  input  wire logic [NUM-1:0] set_in,
  input  wire logic [NUM-1:0] clr_in,
  output logic      [NUM-1:0] flags_out
);

  typedef struct packed {
    logic [NUM-1:0] flags;
  } psir_flag_state_t;

  psir_flag_state_t st_ff;
  psir_flag_state_t nxt_st;

  // ==========================================================================
  // Flags
  // ==========================================================================
  // Set wins over clear so an event during the clearing read is kept.
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.flags = (st_ff.flags & ~clr_in) | set_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flags_out = st_ff.flags;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Each flag is checked on its own so a crossed bit shows up.
  for (genvar i = 0; i < NUM; i++) begin : g_chk
    flag_set_a: assert property (set_in[i] |=> flags_out[i])
      else $error("Event flag not latched.");
    flag_clear_a: assert property (clr_in[i] && !set_in[i] |=> !flags_out[i])
      else $error("Event flag not cleared by read.");
    flag_hold_a: assert property (!clr_in[i] && flags_out[i] |=> flags_out[i])
      else $error("Event flag dropped without a read.");
  end

endmodule : psir_evt_flags
`default_nettype wire

// >>> hdl/psir_regs.sv
// Management register bank with serial management slave, status and event flags.
// What this block does
// - Extended status bits 15 and 14 read as zero, read-only.
// - Extended status bits 13 and 12 read as one, read-only.
// - Loopback register bit 8 enables remote loopback; resets to zero.
// - Loopback register bit 3 enables LED test mode; resets to zero.
// - Loopback reserved fields reset to 0000001, 11, 11; bit 0 reads zero.
// - Link status bit 2 shows gigabit link good, read-only.
// - Link status bit 1 shows 100 Mbit link good, read-only.
// - Sixteen-bit symbol error frame counter, read-only, cleared by read.
// - Interrupt control bit 15 enables the jabber interrupt.
// - Interrupt control bit 14 enables the receive error interrupt.
// - Interrupt control bit 13 enables the page received interrupt.
// - Interrupt control bit 12 enables the parallel detect fault interrupt.
// - Interrupt control bit 11 enables the partner acknowledge interrupt.
// - Interrupt control bit 10 enables the link down interrupt.
// - Interrupt control bit 9 enables the remote fault interrupt.
// - Interrupt control bit 8 enables the link up interrupt.
// - Status bit 7 latches jabber, cleared by reading the register.
// - Status bit 6 latches receive error, cleared by reading.
// - Status bit 5 latches page received, cleared by reading.
// - Status bit 4 latches parallel detect fault, cleared by reading.
// - Status bits 3 to 0 latch acknowledge, down, fault, up; read clears.
// - A control bit sets interrupt pin polarity: one high, zero low.
`timescale 1ns/1ps
`default_nettype none

module psir_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic                             clk_in,
  input  wire logic                             rst_n_in,
  input  wire logic                             mdc_in,
  input  wire logic                             mdio_in,
  output logic                                  mdio_out,
  output logic                                  mdio_oe_out,
  input  wire logic [psir_pkg::NUM_EVENTS-1:0]  event_in,
  input  wire logic                             rx_symbol_error_in,
  input  wire logic                             link_1000_ok_in,
  input  wire logic                             link_100_ok_in,
  output logic                                  remote_loopback_out,
  output logic                                  led_test_out,
  output logic                                  irq_pin_out
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic                                mdc_prev;
    psir_pkg::psir_mdio_state_t          fsm;
    logic [5:0]                          cnt;
    logic [1:0]                          op;
    logic [4:0]                          phy;
    logic [4:0]                          reg_a;
    logic [15:0]                         shift;
    logic                                rd_ok;
    logic                                mdio_drv;
    logic                                mdio_oe;
    logic [15:0]                         loop_led;
    logic [psir_pkg::NUM_EVENTS-1:0]     int_en;
    logic                                int_level;
    logic                                irq_pin;
  } psir_state_t;

  localparam psir_state_t STATE_RESET = '{
    mdc_prev:  1'b0,
    fsm:       psir_pkg::PSIR_IDLE,
    cnt:       6'h00,
    op:        2'h0,
    phy:       5'h00,
    reg_a:     5'h00,
    shift:     16'h0000,
    rd_ok:     1'b0,
    mdio_drv:  1'b0,
    mdio_oe:   1'b0,
    loop_led:  psir_pkg::LOOP_LED_RESET,
    int_en:    8'h00,
    int_level: 1'b0,
    irq_pin:   psir_pkg::IRQ_PIN_RESET
  };

  psir_state_t                           st_ff;
  psir_state_t                           nxt_st;
  logic        [psir_pkg::NUM_EVENTS-1:0] flags_q;
  logic        [psir_pkg::NUM_EVENTS-1:0] flags_clr;
  logic        [15:0]                     err_count_q;
  logic                                   count_clr;
  logic                                   rd_capture;
  logic                                   wr_en;
  logic        [4:0]                      wr_addr;
  logic        [15:0]                     wr_data;
  logic        [15:0]                     rd_value;
  logic                                   irq_active;

  // ==========================================================================
  // Event flags and error counter
  // ==========================================================================
  psir_evt_flags #(
    .NUM (psir_pkg::NUM_EVENTS)
  ) u_flags (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .set_in    (event_in),
    .clr_in    (flags_clr),
    .flags_out (flags_q)
  );

  psir_err_count #(
    .WIDTH (psir_pkg::ERR_COUNT_WIDTH)
  ) u_err_count (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .inc_in    (rx_symbol_error_in),
    .clr_in    (count_clr),
    .count_out (err_count_q)
  );

  // ==========================================================================
  // Read data selection
  // ==========================================================================
  // Unmapped and excluded addresses read as zero so software sees no junk.
  always_comb begin
    rd_value = 16'h0000;
    unique case ({st_ff.reg_a[3:0], mdio_in})
      psir_pkg::REG_EXT_STATUS: begin
        rd_value = psir_pkg::EXT_STATUS_VALUE;
      end
      psir_pkg::REG_LOOP_LED: begin
        rd_value = st_ff.loop_led;
      end
      psir_pkg::REG_LINK_STATUS: begin
        rd_value[psir_pkg::LINK_1000_BIT] = link_1000_ok_in;
        rd_value[psir_pkg::LINK_100_BIT]  = link_100_ok_in;
      end
      psir_pkg::REG_RX_ERR_COUNT: begin
        rd_value = err_count_q;
      end
      psir_pkg::REG_INT_CTRL: begin
        rd_value = {st_ff.int_en, flags_q};
      end
      psir_pkg::REG_PHY_CTRL: begin
        rd_value[psir_pkg::INT_LEVEL_BIT] = st_ff.int_level;
      end
      default: begin
        rd_value = 16'h0000;
      end
    endcase
  end

  // ==========================================================================
  // Management frame engine and register writes
  // ==========================================================================
  // The clock pin is sampled here, so each MDC rising edge becomes one
  // system-clock step; MDC must stay well below a quarter of clk_in.
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.mdc_prev = mdc_in;
    rd_capture      = 1'b0;
    wr_en           = 1'b0;
    wr_addr         = st_ff.reg_a;
    wr_data         = {st_ff.shift[14:0], mdio_in};
    flags_clr       = '0;
    count_clr       = 1'b0;
    if (mdc_in && !st_ff.mdc_prev) begin
      unique case (st_ff.fsm)
        psir_pkg::PSIR_IDLE: begin
          if (mdio_in) begin
            if (st_ff.cnt != psir_pkg::PREAMBLE_BITS) begin
              nxt_st.cnt = st_ff.cnt + 6'h01;
            end
          end else if (st_ff.cnt == psir_pkg::PREAMBLE_BITS) begin
            nxt_st.fsm = psir_pkg::PSIR_START;
            nxt_st.cnt = 6'h00;
          end else begin
            nxt_st.cnt = 6'h00;
          end
        end
        psir_pkg::PSIR_START: begin
          nxt_st.fsm = mdio_in ? psir_pkg::PSIR_OPC : psir_pkg::PSIR_IDLE;
          nxt_st.cnt = 6'h00;
        end
        psir_pkg::PSIR_OPC: begin
          nxt_st.op  = {st_ff.op[0], mdio_in};
          nxt_st.cnt = st_ff.cnt + 6'h01;
          if (st_ff.cnt != 6'h00) begin
            nxt_st.cnt = 6'h00;
            if (({st_ff.op[0], mdio_in} == psir_pkg::OP_READ) ||
                ({st_ff.op[0], mdio_in} == psir_pkg::OP_WRITE)) begin
              nxt_st.fsm = psir_pkg::PSIR_PHYA;
            end else begin
              nxt_st.fsm = psir_pkg::PSIR_IDLE;
            end
          end
        end
        psir_pkg::PSIR_PHYA: begin
          nxt_st.phy = {st_ff.phy[3:0], mdio_in};
          nxt_st.cnt = st_ff.cnt + 6'h01;
          if (st_ff.cnt == psir_pkg::FIELD_LAST) begin
            nxt_st.fsm = psir_pkg::PSIR_REGA;
            nxt_st.cnt = 6'h00;
          end
        end
        psir_pkg::PSIR_REGA: begin
          nxt_st.reg_a = {st_ff.reg_a[3:0], mdio_in};
          nxt_st.cnt   = st_ff.cnt + 6'h01;
          if (st_ff.cnt == psir_pkg::FIELD_LAST) begin
            nxt_st.fsm   = psir_pkg::PSIR_TURN;
            nxt_st.cnt   = 6'h00;
            nxt_st.rd_ok = (st_ff.op == psir_pkg::OP_READ) && (st_ff.phy == PHY_ADDR);
            if (nxt_st.rd_ok) begin
              // Snapshot and clear in one cycle; new events still set flags.
              rd_capture   = 1'b1;
              nxt_st.shift = rd_value;
              if ({st_ff.reg_a[3:0], mdio_in} == psir_pkg::REG_INT_CTRL) begin
                flags_clr = '1;
              end
              if ({st_ff.reg_a[3:0], mdio_in} == psir_pkg::REG_RX_ERR_COUNT) begin
                count_clr = 1'b1;
              end
            end
          end
        end
        psir_pkg::PSIR_TURN: begin
          nxt_st.cnt = st_ff.cnt + 6'h01;
          if (st_ff.cnt == 6'h00) begin
            nxt_st.mdio_oe  = st_ff.rd_ok;
            nxt_st.mdio_drv = 1'b0;
          end else begin
            nxt_st.fsm      = psir_pkg::PSIR_DATA;
            nxt_st.cnt      = 6'h00;
            nxt_st.mdio_drv = st_ff.shift[15];
            if (st_ff.rd_ok) begin
              nxt_st.shift = {st_ff.shift[14:0], 1'b0};
            end
          end
        end
        psir_pkg::PSIR_DATA: begin
          nxt_st.cnt = st_ff.cnt + 6'h01;
          if (st_ff.rd_ok) begin
            nxt_st.mdio_drv = st_ff.shift[15];
            nxt_st.shift    = {st_ff.shift[14:0], 1'b0};
          end else begin
            nxt_st.shift = wr_data;
          end
          if (st_ff.cnt == psir_pkg::DATA_LAST) begin
            nxt_st.fsm      = psir_pkg::PSIR_IDLE;
            nxt_st.cnt      = 6'h00;
            nxt_st.mdio_oe  = 1'b0;
            nxt_st.mdio_drv = 1'b0;
            wr_en           = (st_ff.op == psir_pkg::OP_WRITE) && (st_ff.phy == PHY_ADDR);
          end
        end
        default: begin
          nxt_st.fsm = psir_pkg::PSIR_IDLE;
          nxt_st.cnt = 6'h00;
        end
      endcase
    end
    // Only writable fields take write data; read-only ones keep their value.
    if (wr_en) begin
      unique case (wr_addr)
        psir_pkg::REG_LOOP_LED: begin
          nxt_st.loop_led = wr_data & psir_pkg::LOOP_LED_WMASK;
        end
        psir_pkg::REG_INT_CTRL: begin
          nxt_st.int_en = wr_data[15:psir_pkg::INT_EN_LSB];
        end
        psir_pkg::REG_PHY_CTRL: begin
          nxt_st.int_level = wr_data[psir_pkg::INT_LEVEL_BIT];
        end
        default: begin
          nxt_st.int_level = st_ff.int_level;
        end
      endcase
    end
    // Pin is registered so the output has no glitch from the flag logic.
    irq_active     = |(flags_q & st_ff.int_en);
    nxt_st.irq_pin = st_ff.int_level ? irq_active : !irq_active;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign mdio_out            = st_ff.mdio_drv;
  assign mdio_oe_out         = st_ff.mdio_oe;
  assign remote_loopback_out = st_ff.loop_led[psir_pkg::LOOP_REMOTE_BIT];
  assign led_test_out        = st_ff.loop_led[psir_pkg::LOOP_LED_BIT];
  assign irq_pin_out         = st_ff.irq_pin;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence loop_write_s;
    wr_en && (wr_addr == psir_pkg::REG_LOOP_LED);
  endsequence

  sequence int_write_s;
    wr_en && (wr_addr == psir_pkg::REG_INT_CTRL);
  endsequence

  sequence ext_read_s;
    rd_capture && ({st_ff.reg_a[3:0], mdio_in} == psir_pkg::REG_EXT_STATUS);
  endsequence

  sequence link_read_s;
    rd_capture && ({st_ff.reg_a[3:0], mdio_in} == psir_pkg::REG_LINK_STATUS);
  endsequence

  ext_x_zero_a: assert property (ext_read_s |=> st_ff.shift[15:14] == 2'h0)
    else $error("Extended status reports 1000Base-X ability.");
  ext_t_ones_a: assert property (ext_read_s |=> st_ff.shift[13:12] == 2'h3)
    else $error("Extended status lacks 1000Base-T ability.");
  remote_loop_a: assert property (
    loop_write_s |=> remote_loopback_out == $past(wr_data[psir_pkg::LOOP_REMOTE_BIT]))
    else $error("Remote loopback did not follow write.");
  led_test_a: assert property (
    loop_write_s |=> led_test_out == $past(wr_data[psir_pkg::LOOP_LED_BIT]))
    else $error("LED test did not follow write.");
  loop_bit0_a: assert property (st_ff.loop_led[0] == 1'b0)
    else $error("Read-only loopback bit 0 is set.");
  link_1000_a: assert property (
    link_read_s |=> st_ff.shift[psir_pkg::LINK_1000_BIT] == $past(link_1000_ok_in))
    else $error("Gigabit link bit wrong.");
  link_100_a: assert property (
    link_read_s |=> st_ff.shift[psir_pkg::LINK_100_BIT] == $past(link_100_ok_in))
    else $error("100 Mbit link bit wrong.");
  int_enable_a: assert property (
    int_write_s |=> st_ff.int_en == $past(wr_data[15:8]) ##1 irq_active ==
      |(flags_q & $past(wr_data[15:8], 2)) || !$stable(st_ff.int_en))
    else $error("Interrupt enables did not follow write.");
  irq_level_a: assert property (
    (irq_active && st_ff.int_level) ##1 st_ff.int_level |-> irq_pin_out)
    else $error("Active-high interrupt pin not asserted.");
  irq_quiet_a: assert property (
    !irq_active [*2] ##0 $stable(st_ff.int_level) |-> irq_pin_out == !st_ff.int_level)
    else $error("Interrupt pin asserted with no enabled flag.");
  ro_write_a: assert property (
    wr_en && (wr_addr == psir_pkg::REG_RX_ERR_COUNT) && !rx_symbol_error_in
      |=> err_count_q == $past(err_count_q))
    else $error("Write altered the error counter.");

endmodule : psir_regs
`default_nettype wire

// >>> verification/psir_mdio_host.sv
// Station management controller model that runs serial management frames.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Frame driver
// ============================================================================
module psir_mdio_host #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic clk_in,
  input  wire logic mdio_in,
  output logic      mdc_out,
  output logic      mdio_out,
  output logic      mdio_oe_out
);
  // The clock stands low between frames and the line is left to its pull-up.
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_oe_out = 1'b0;
  end

  // Each clock phase lasts three system clocks, above the two-clock minimum.
  task automatic frame(input logic [1:0] op, input logic [4:0] addr,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, op, PHY_ADDR, addr, 2'b10, wdata};
    rdata = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_in) #1;
      mdc_out = 1'b0;
      mdio_out = bits[63-i];
      mdio_oe_out = (op == psir_pkg::OP_WRITE) || (i < 46);
      repeat (3) @(posedge clk_in);
      #1;
      mdc_out = 1'b1;
      if (i >= 48) rdata[63-i] = mdio_in; // Sampled before the device moves on.
      repeat (2) @(posedge clk_in);
    end
    @(posedge clk_in) #1;
    mdc_out = 1'b0;
    mdio_oe_out = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : frame
endmodule : psir_mdio_host

`default_nettype wire

// >>> verification/tb_psir_regs.sv
// Self-checking testbench for the PHY status and interrupt register bank.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Testbench top
// ============================================================================
module tb_psir_regs;
  logic       clk_in, rst_n_in, mdc, host_mdio, host_oe, dev_mdio, dev_oe, mdio_wire;
  logic [7:0] event_in;
  logic       rx_err, link_1000, link_100, loop_out, led_out, irq_out;
  int         failures, check_count;
  int         cycles = 0;

  // The line has a pull-up, so it reads high while nobody drives it.
  assign mdio_wire = dev_oe ? dev_mdio : (host_oe ? host_mdio : 1'b1);

  psir_regs psir_regs_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .mdc_in(mdc),
    .mdio_in(mdio_wire), .mdio_out(dev_mdio), .mdio_oe_out(dev_oe), .event_in(event_in),
    .rx_symbol_error_in(rx_err), .link_1000_ok_in(link_1000), .link_100_ok_in(link_100),
    .remote_loopback_out(loop_out), .led_test_out(led_out), .irq_pin_out(irq_out));
  psir_mdio_host psir_mdio_host_i (.clk_in(clk_in), .mdio_in(mdio_wire), .mdc_out(mdc),
    .mdio_out(host_mdio), .mdio_oe_out(host_oe));

  task automatic conclude();
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string name);
    logic [15:0] d;
    psir_mdio_host_i.frame(psir_pkg::OP_READ, a, 16'h0000, d);
    check(name, d, exp);
  endtask : rd

  // Extra cycles let the written value reach the register outputs and the pin.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] unused;
    psir_mdio_host_i.frame(psir_pkg::OP_WRITE, a, d, unused);
    repeat (3) @(posedge clk_in);
    #1;
  endtask : wr

  task automatic pulse(input logic [7:0] ev, input logic err);
    @(posedge clk_in) #1;
    event_in = ev;
    rx_err = err;
    @(posedge clk_in) #1;
    event_in = 8'h00;
    rx_err = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : pulse

  task automatic test_reset();
    check("irq_pin", irq_out, 16'h0001);
    wr(psir_pkg::REG_EXT_STATUS, 16'hffff);
    rd(psir_pkg::REG_EXT_STATUS, 16'h3000, "ext_status");
    rd(psir_pkg::REG_LOOP_LED, 16'h02f0, "loop_led");
    rd(psir_pkg::REG_INT_CTRL, 16'h0000, "int_ctrl");
    wr(psir_pkg::REG_CABLE_DIAG, 16'hffff);
    rd(psir_pkg::REG_CABLE_DIAG, 16'h0000, "cable_diag");
  endtask : test_reset

  task automatic test_loop_led();
    wr(psir_pkg::REG_LOOP_LED, 16'hffff);
    check("loopback", {loop_out, led_out}, 16'h0003);
    rd(psir_pkg::REG_LOOP_LED, 16'hfffe, "loop_led");
    wr(psir_pkg::REG_LOOP_LED, 16'h02f0);
    check("loopback", {loop_out, led_out}, 16'h0000);
  endtask : test_loop_led

  task automatic test_link();
    link_1000 = 1'b1;
    rd(psir_pkg::REG_LINK_STATUS, 16'h0004, "link");
    link_1000 = 1'b0;
    link_100 = 1'b1;
    rd(psir_pkg::REG_LINK_STATUS, 16'h0002, "link");
    link_100 = 1'b0;
  endtask : test_link

  task automatic test_counter();
    rd(psir_pkg::REG_RX_ERR_COUNT, 16'h0000, "err_count");
    repeat (3) pulse(8'h00, 1'b1);
    wr(psir_pkg::REG_RX_ERR_COUNT, 16'h0000);
    rd(psir_pkg::REG_RX_ERR_COUNT, 16'h0003, "err_count");
    rd(psir_pkg::REG_RX_ERR_COUNT, 16'h0000, "err_count");
  endtask : test_counter

  // A disabled event must not drive the pin; the low byte of a write is ignored.
  task automatic test_events();
    logic [7:0] ev, other;
    for (int k = 0; k < 8; k++) begin
      ev = 8'h01 << k;
      other = 8'h01 << ((k + 1) % 8);
      wr(psir_pkg::REG_INT_CTRL, {ev, 8'hff});
      pulse(other, 1'b0);
      check("irq_pin", irq_out, 16'h0001);
      pulse(ev, 1'b0);
      check("irq_pin", irq_out, 16'h0000);
      rd(psir_pkg::REG_INT_CTRL, {ev, ev | other}, "int_ctrl");
      check("irq_pin", irq_out, 16'h0001);
      rd(psir_pkg::REG_INT_CTRL, {ev, 8'h00}, "int_ctrl");
    end
  endtask : test_events

  task automatic test_polarity();
    wr(psir_pkg::REG_PHY_CTRL, 16'h4000);
    check("irq_pin", irq_out, 16'h0000);
    pulse(8'h80, 1'b0);
    check("irq_pin", irq_out, 16'h0001);
    rd(psir_pkg::REG_INT_CTRL, 16'h8080, "int_ctrl");
    check("irq_pin", irq_out, 16'h0000);
  endtask : test_polarity

  // A reset in mid-run must bring the loopback controls and the interrupt pin level back to their reset values.
  task automatic test_mid_reset();
    wr(psir_pkg::REG_LOOP_LED, 16'hffff);
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    check("loopback", {loop_out, led_out}, 16'h0000);
    check("irq_pin", irq_out, 16'h0001);
    repeat (2) @(posedge clk_in);
    #1;
    rd(psir_pkg::REG_LOOP_LED, 16'h02f0, "loop_led");
  endtask : test_mid_reset

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Cuts a hang short well beyond the length of the planned frames.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    rst_n_in = 1'b0;
    event_in = 8'h00;
    rx_err = 1'b0;
    link_1000 = 1'b0;
    link_100 = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (16) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    repeat (2) @(posedge clk_in);
    test_reset();
    test_loop_led();
    test_link();
    test_counter();
    test_events();
    test_polarity();
    test_mid_reset();
    conclude();
  end
endmodule : tb_psir_regs

`default_nettype wire
